// ### phport_params.svh
// Timing counts, widths, field positions and reset values of the peripheral handshake port.
// Assumes a single system clock whose period is given below.
`ifndef PHPORT_PARAMS_SVH
`define PHPORT_PARAMS_SVH

`define PHPORT_DATA_W 18
`define PHPORT_CTRL_W 3
`define PHPORT_STS_W 3
`define PHPORT_FIFO_CHIPS 5
`define PHPORT_CNT_W 4

`define PHPORT_CLK_PERIOD_NS 10
`define PHPORT_SETUP_NS 50
`define PHPORT_MIN_DEASSERT_NS 65
`define PHPORT_CEIL_CYC(ns) (((ns) + `PHPORT_CLK_PERIOD_NS - 1) / `PHPORT_CLK_PERIOD_NS)
`define PHPORT_SETUP_CYC `PHPORT_CEIL_CYC(`PHPORT_SETUP_NS)
`define PHPORT_MIN_DEASSERT_CYC `PHPORT_CEIL_CYC(`PHPORT_MIN_DEASSERT_NS)

`define PHPORT_SYNC_STS_LSB 0
`define PHPORT_SYNC_ATTENTION_INPUT 3
`define PHPORT_SYNC_ACK 4
`define PHPORT_SYNC_W 5

`define PHPORT_CTRL_RST 3'h0
`define PHPORT_DATA_RST 18'h00000
`define PHPORT_CNT_RST 4'h0

`endif

// ### phport_pkg.sv
// Types shared by the peripheral handshake port modules.
// Assumes phport_params.svh is on the include path.
`include "phport_params.svh"

package phport_pkg;

   // ----------------------------------------------------------------------
   // Software control bits
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [`PHPORT_CTRL_W-1:0] ctrl_bits;
      logic dir;
      logic edge_sel;
      logic periph_enable;
      logic attention_input_req_enable;
   } phport_ctrl_t;

   // ----------------------------------------------------------------------
   // Handshake sequencer
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_IN_REQ,
      ST_IN_SETUP,
      ST_IN_SHIFT,
      ST_TRAIL,
      ST_OUT_SETUP,
      ST_OUT_REQ,
      ST_HOLD
   } phport_state_t;

   typedef struct packed {
      phport_state_t state;
      logic [`PHPORT_CNT_W-1:0] cnt;
      logic ack_d;
      logic attention_input_d;
      logic attention_input_latch;
      logic request;
      logic shift_in;
      logic shift_out;
      logic [`PHPORT_DATA_W-1:0] wr_data;
      logic [`PHPORT_DATA_W-1:0] bus_data;
      logic bus_oe_n;
      logic [`PHPORT_CTRL_W-1:0] ctrl_bits;
      logic dir_p;
      logic dir_n;
      logic [`PHPORT_STS_W-1:0] status_bits;
      logic ack_status;
      logic attention_input_sense_n;
      logic attention_input_req_n;
      logic attention_input_poll_resp;
      logic srq_poll_resp;
   } phport_regs_t;

endpackage

// ### phport_sync.sv
// Two-stage synchroniser for a group of level inputs.
// Assumes the inputs change slowly compared to the clock.
`timescale 1ns/1ps
`include "phport_params.svh"

module phport_sync
   import phport_pkg::*;
#(
   parameter int W = `PHPORT_SYNC_W
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Levels
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } phport_sync_st_t;

   phport_sync_st_t st;
   phport_sync_st_t next_st;

   always_comb begin
      next_st.s1 = d_in;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q_out = st.s2;

endmodule

// ### phport_top.sv
// Peripheral handshake port: request/acknowledge word transfer between the card FIFO and a
// peripheral, plus control, status, direction and attention lines.
// Assumes all inputs are synchronous to clk_sys_in and unconnected lines read as 0.
//
// Functional notes
// - Control bits driven straight from control word.
// - Status inputs synchronised, shown as status bits.
// - Attention assertion sets latch unless in reset.
// - Latch and enable drive attention request low.
// - Reset, device clear, status read clear latch.
// - Direction pair follows direction bit, high outward.
// - Eighteen-bit shared bus, never both ends driving.
// - Request asks word; peripheral answers with acknowledge.
// - Undriven acknowledge reads as zero, deasserted only with edge select zero.
// - Input direction ignores service polls when empty.
// - Input: request while enabled and five ready.
// - Delay acknowledge edge for data setup, deskew.
// - Delayed edge makes shift-in, gated by ready.
// - After shift-in, request low for minimum time.
// - Reassert request only when all chips ready.
// - Keeps requesting while space, ignores word count.
// - Edge select one uses falling acknowledge edge.
// - Request stays until acknowledge trailing edge passes.
// - Output: request after word driven with setup.
`timescale 1ns/1ps
`include "phport_params.svh"

module phport_top
   import phport_pkg::*;
#(
   parameter logic [`PHPORT_CNT_W-1:0] SETUP_CYC = `PHPORT_CNT_W'(`PHPORT_SETUP_CYC),
   parameter logic [`PHPORT_CNT_W-1:0] MIN_DEASSERT_CYC =
      `PHPORT_CNT_W'(`PHPORT_MIN_DEASSERT_CYC)
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Card control and backplane events
   input wire phport_ctrl_t ctrl_in,
   input wire logic device_clear_in,
   input wire logic status_read_in,
   input wire logic srq_poll_in,
   input wire logic attention_input_poll_in,
   input wire logic fifo_not_empty_in,
   // Card status and backplane answers
   output logic [`PHPORT_STS_W-1:0] status_bits_out,
   output logic ack_status_out,
   output logic attention_input_sense_n_out,
   output logic attention_input_req_n_out,
   output logic attention_input_poll_resp_out,
   output logic srq_poll_resp_out,
   // FIFO input side
   input wire logic [`PHPORT_FIFO_CHIPS-1:0] fifo_input_ready_in,
   output logic fifo_shift_in_pulse_out,
   output logic [`PHPORT_DATA_W-1:0] fifo_wr_data_out,
   // FIFO output side
   input wire logic fifo_rd_valid_in,
   input wire logic [`PHPORT_DATA_W-1:0] fifo_rd_data_in,
   output logic fifo_shift_out_out,
   // Peripheral connector
   output logic [`PHPORT_CTRL_W-1:0] ctrl_bits_out,
   input wire logic [`PHPORT_STS_W-1:0] status_bits_in,
   input wire logic attention_input_in,
   output logic direction_out_pair_p_out,
   output logic direction_out_pair_n_out,
   output logic xfer_request_out,
   input wire logic xfer_ack_in,
   input wire logic [`PHPORT_DATA_W-1:0] data_in,
   output logic [`PHPORT_DATA_W-1:0] data_out,
   output logic data_oe_n_out
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [`PHPORT_CNT_W-1:0] cnt_load(input logic [`PHPORT_CNT_W-1:0] cyc);
      cnt_load = cyc - `PHPORT_CNT_W'(1);
   endfunction

   function automatic logic is_req_state(input phport_state_t s);
      is_req_state = (s == ST_IN_REQ) || (s == ST_IN_SETUP) || (s == ST_IN_SHIFT) ||
                     (s == ST_TRAIL) || (s == ST_OUT_REQ);
   endfunction

   // ----------------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------------
   logic [`PHPORT_SYNC_W-1:0] sync_q;
   logic [`PHPORT_STS_W-1:0] sts_s;
   logic attention_input_s;
   logic ack_s;
   logic act_level;
   logic act_prev;
   logic ack_edge;
   logic all_ready;
   logic attention_input_rise;

   phport_sync #(
      .W(`PHPORT_SYNC_W)
   ) u_sync (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .d_in({xfer_ack_in, attention_input_in, status_bits_in}),
      .q_out(sync_q)
   );

   phport_regs_t st;
   phport_regs_t next_st;

   assign sts_s = sync_q[`PHPORT_SYNC_STS_LSB +: `PHPORT_STS_W];
   assign attention_input_s = sync_q[`PHPORT_SYNC_ATTENTION_INPUT];
   assign ack_s = sync_q[`PHPORT_SYNC_ACK];
   assign act_level = ack_s ^ ctrl_in.edge_sel;
   assign act_prev = st.ack_d ^ ctrl_in.edge_sel;
   assign ack_edge = act_level & ~act_prev;
   assign all_ready = &fifo_input_ready_in;
   assign attention_input_rise = attention_input_s & ~st.attention_input_d;

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.shift_in = 1'b0;
      next_st.shift_out = 1'b0;
      next_st.ack_d = ack_s;
      next_st.attention_input_d = attention_input_s;
      next_st.ctrl_bits = ctrl_in.ctrl_bits;
      next_st.dir_p = ctrl_in.dir;
      next_st.dir_n = ~ctrl_in.dir;
      next_st.bus_oe_n = ~ctrl_in.dir;
      next_st.status_bits = sts_s;
      next_st.ack_status = ack_s;
      next_st.attention_input_latch = attention_input_rise | (st.attention_input_latch & ~(device_clear_in | status_read_in));
      next_st.attention_input_sense_n = ~next_st.attention_input_latch;
      next_st.attention_input_req_n = ~(next_st.attention_input_latch & ctrl_in.attention_input_req_enable);
      next_st.attention_input_poll_resp = attention_input_poll_in & next_st.attention_input_latch & ctrl_in.attention_input_req_enable;
      next_st.srq_poll_resp = srq_poll_in & (ctrl_in.dir | fifo_not_empty_in);
      if (st.cnt != `PHPORT_CNT_RST) begin
         next_st.cnt = st.cnt - `PHPORT_CNT_W'(1);
      end
      unique case (st.state)
         ST_IDLE: begin
            if (ctrl_in.periph_enable) begin
               if (!ctrl_in.dir && all_ready) begin
                  next_st.state = ST_IN_REQ;
               end else if (ctrl_in.dir && fifo_rd_valid_in) begin
                  next_st.shift_out = 1'b1;
                  next_st.bus_data = fifo_rd_data_in;
                  next_st.cnt = cnt_load(SETUP_CYC);
                  next_st.state = ST_OUT_SETUP;
               end
            end
         end
         ST_IN_REQ: begin
            if (ack_edge) begin
               next_st.cnt = cnt_load(SETUP_CYC);
               next_st.state = ST_IN_SETUP;
            end
         end
         ST_IN_SETUP: begin
            if (st.cnt == `PHPORT_CNT_RST) begin
               next_st.state = ST_IN_SHIFT;
            end
         end
         ST_IN_SHIFT: begin
            if (all_ready) begin
               next_st.shift_in = 1'b1;
               next_st.wr_data = data_in;
               next_st.state = ST_TRAIL;
            end
         end
         ST_TRAIL: begin
            if (!act_level) begin
               next_st.cnt = cnt_load(MIN_DEASSERT_CYC);
               next_st.state = ST_HOLD;
            end
         end
         ST_OUT_SETUP: begin
            if (st.cnt == `PHPORT_CNT_RST) begin
               next_st.state = ST_OUT_REQ;
            end
         end
         ST_OUT_REQ: begin
            if (ack_edge) begin
               next_st.state = ST_TRAIL;
            end
         end
         ST_HOLD: begin
            if (st.cnt == `PHPORT_CNT_RST) begin
               if (ctrl_in.periph_enable && !ctrl_in.dir && all_ready) begin
                  next_st.state = ST_IN_REQ;
               end else begin
                  next_st.state = ST_IDLE;
               end
            end
         end
      endcase
      if (!ctrl_in.periph_enable && st.state != ST_HOLD) begin
         next_st.state = ST_IDLE;
      end
      next_st.request = is_req_state(next_st.state);
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
         st.state <= ST_IDLE;
         st.ctrl_bits <= `PHPORT_CTRL_RST;
         st.dir_n <= 1'b1;
         st.bus_oe_n <= 1'b1;
         st.attention_input_sense_n <= 1'b1;
         st.attention_input_req_n <= 1'b1;
         st.wr_data <= `PHPORT_DATA_RST;
         st.bus_data <= `PHPORT_DATA_RST;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign status_bits_out = st.status_bits;
   assign ack_status_out = st.ack_status;
   assign attention_input_sense_n_out = st.attention_input_sense_n;
   assign attention_input_req_n_out = st.attention_input_req_n;
   assign attention_input_poll_resp_out = st.attention_input_poll_resp;
   assign srq_poll_resp_out = st.srq_poll_resp;
   assign fifo_shift_in_pulse_out = st.shift_in;
   assign fifo_wr_data_out = st.wr_data;
   assign fifo_shift_out_out = st.shift_out;
   assign ctrl_bits_out = st.ctrl_bits;
   assign direction_out_pair_p_out = st.dir_p;
   assign direction_out_pair_n_out = st.dir_n;
   assign xfer_request_out = st.request;
   assign data_out = st.bus_data;
   assign data_oe_n_out = st.bus_oe_n;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);

   ctrl_pass_a: assert property (##1 ctrl_bits_out == $past(ctrl_in.ctrl_bits))
      else $error("control bits do not follow control word");
   status_sync_a: assert property (##3 status_bits_out == $past(status_bits_in, 3))
      else $error("status bits not three cycles behind inputs");
   attention_input_set_a: assert property (attention_input_rise |=> !attention_input_sense_n_out)
      else $error("attention edge did not set latch");
   attention_input_drive_a: assert property (##1 attention_input_req_n_out ==
      !(!attention_input_sense_n_out && $past(ctrl_in.attention_input_req_enable)))
      else $error("attention request line wrong");
   attention_input_clear_a: assert property ((status_read_in || device_clear_in) && !attention_input_rise
      |=> attention_input_sense_n_out)
      else $error("attention latch not cleared");
   dir_pair_a: assert property (##1 (direction_out_pair_p_out == $past(ctrl_in.dir)) &&
      (direction_out_pair_n_out != direction_out_pair_p_out))
      else $error("direction pair wrong");
   bus_drive_a: assert property (!data_oe_n_out |-> direction_out_pair_p_out)
      else $error("bus driven in input direction");
   srq_ignore_a: assert property (srq_poll_resp_out |->
      $past(ctrl_in.dir || fifo_not_empty_in))
      else $error("service poll answered with empty fifo");
   in_req_a: assert property ($rose(xfer_request_out) && !direction_out_pair_p_out
      |-> $past(all_ready))
      else $error("input request without fifo ready");
   shift_gate_a: assert property (fifo_shift_in_pulse_out |-> $past(all_ready))
      else $error("shift-in without all ready");
   // Low cycles of the request since it last stood high, saturating.
   logic [`PHPORT_CNT_W-1:0] req_low_cyc;
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         req_low_cyc <= '1;
      end else begin
         req_low_cyc <= xfer_request_out ? '0 : req_low_cyc + `PHPORT_CNT_W'(~&req_low_cyc);
      end
   end
   req_hold_a: assert property ($rose(xfer_request_out) && $past(st.state) == ST_HOLD
      |-> req_low_cyc >= MIN_DEASSERT_CYC)
      else $error("request low shorter than minimum");
   req_trail_a: assert property ($fell(xfer_request_out) |->
      $past(!act_level || !ctrl_in.periph_enable))
      else $error("request dropped before trailing edge");
   out_setup_a: assert property ($rose(xfer_request_out) && direction_out_pair_p_out
      |-> $past(fifo_shift_out_out, SETUP_CYC))
      else $error("output request without setup delay");

   in_word_c: cover property (st.state == ST_IN_REQ ##[1:40] fifo_shift_in_pulse_out);
   out_word_c: cover property (fifo_shift_out_out ##[1:40] $fell(xfer_request_out));
   falling_mode_c: cover property (ctrl_in.edge_sel && ack_edge && xfer_request_out);
   attention_input_c: cover property (attention_input_rise ##1 !attention_input_req_n_out);

endmodule

// ### phport_periph_model.sv
// Peripheral model on the cable side of the handshake port.
// Assumes the bench resolves the shared data bus from the card's output enable.
`timescale 1ns/1ps
`include "phport_params.svh"

module phport_periph_model
   import phport_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Cable side
   input wire logic request_in,
   input wire logic dir_in,
   input wire logic edge_sel_in,
   input wire logic [`PHPORT_DATA_W-1:0] card_data_in,
   output logic ack_out,
   output logic [`PHPORT_DATA_W-1:0] data_out,
   output logic oe_n_out,
   // Bench side
   output logic [`PHPORT_DATA_W-1:0] word_out,
   output logic sent_stb_out,
   output logic rx_stb_out
);
   logic ack_act = '0;
   int wait_cnt;

   assign ack_out = ack_act ^ edge_sel_in;

   initial begin
      data_out = '0;
      oe_n_out = 1'h1;
      word_out = '0;
      sent_stb_out = '0;
      rx_stb_out = '0;
   end

   // ----------------------------------------------------------------------
   // Word handshake
   // ----------------------------------------------------------------------
   always begin
      @(posedge clk_sys_in);
      if (rst_n_in && request_in) begin
         repeat ($urandom_range(0, 6)) @(posedge clk_sys_in);
         #1;
         if (dir_in) begin
            word_out = card_data_in;
            rx_stb_out = 1'h1;
         end else begin
            word_out = `PHPORT_DATA_W'($urandom);
            data_out = word_out;
            oe_n_out = '0;
            sent_stb_out = 1'h1;
         end
         @(posedge clk_sys_in);
         #1;
         rx_stb_out = '0;
         sent_stb_out = '0;
         ack_act = 1'h1;
         repeat ($urandom_range(1, 12)) @(posedge clk_sys_in);
         #1;
         ack_act = '0;
         wait_cnt = 0;
         while (request_in && wait_cnt < 200) begin
            @(posedge clk_sys_in);
            wait_cnt++;
         end
         #1;
         oe_n_out = 1'h1;
         data_out = ~data_out;
      end
   end
endmodule

// ### phport_top_tb.sv
// Self-checking bench for the peripheral handshake port.
// Assumes the port package, its header and the peripheral model are compiled first.
`timescale 1ns/1ps
`include "phport_params.svh"

module phport_top_tb;
   import phport_pkg::*;
   localparam int MINLOW = 3;
   logic clk_sys_in = '0;
   logic rst_n_in = '0;
   phport_ctrl_t ctrl_in = '0;
   logic device_clear_in = '0, status_read_in = '0, srq_poll_in = '0, attention_input_poll_in = '0;
   logic fifo_not_empty_in = '0, fifo_rd_valid_in = '0, attention_input_in = '0;
   logic [`PHPORT_FIFO_CHIPS-1:0] fifo_input_ready_in = '1, rdy_q;
   logic [`PHPORT_DATA_W-1:0] fifo_rd_data_in = '0, data_in, per_data, per_word;
   logic [`PHPORT_DATA_W-1:0] data_out, fifo_wr_data_out;
   logic [`PHPORT_DATA_W-1:0] exp_q[$];
   logic [`PHPORT_STS_W-1:0] status_bits_in = '0, status_bits_out;
   logic [`PHPORT_CTRL_W-1:0] ctrl_bits_out;
   logic ack_status_out, attention_input_sense_n_out, attention_input_req_n_out, attention_input_poll_resp_out;
   logic srq_poll_resp_out, fifo_shift_in_pulse_out, fifo_shift_out_out;
   logic direction_out_pair_p_out, direction_out_pair_n_out, xfer_request_out;
   logic xfer_ack_in, data_oe_n_out, per_oe_n, sent_stb, rx_stb, req_q, sin, sout;
   int error_cnt = 0, check_count = 0, low_cnt = 0, rdy_wait = 0, words = 0, i;

   always #5 clk_sys_in = ~clk_sys_in;
   assign data_in = data_oe_n_out ? per_data : data_out;

   phport_top #(
      .SETUP_CYC(`PHPORT_CNT_W'(2)),
      .MIN_DEASSERT_CYC(`PHPORT_CNT_W'(MINLOW))
   ) uut (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ctrl_in(ctrl_in),
      .device_clear_in(device_clear_in), .status_read_in(status_read_in),
      .srq_poll_in(srq_poll_in), .attention_input_poll_in(attention_input_poll_in),
      .fifo_not_empty_in(fifo_not_empty_in), .status_bits_out(status_bits_out),
      .ack_status_out(ack_status_out), .attention_input_sense_n_out(attention_input_sense_n_out),
      .attention_input_req_n_out(attention_input_req_n_out), .attention_input_poll_resp_out(attention_input_poll_resp_out),
      .srq_poll_resp_out(srq_poll_resp_out), .fifo_input_ready_in(fifo_input_ready_in),
      .fifo_shift_in_pulse_out(fifo_shift_in_pulse_out), .fifo_wr_data_out(fifo_wr_data_out),
      .fifo_rd_valid_in(fifo_rd_valid_in), .fifo_rd_data_in(fifo_rd_data_in),
      .fifo_shift_out_out(fifo_shift_out_out), .ctrl_bits_out(ctrl_bits_out),
      .status_bits_in(status_bits_in), .attention_input_in(attention_input_in),
      .direction_out_pair_p_out(direction_out_pair_p_out),
      .direction_out_pair_n_out(direction_out_pair_n_out),
      .xfer_request_out(xfer_request_out), .xfer_ack_in(xfer_ack_in), .data_in(data_in),
      .data_out(data_out), .data_oe_n_out(data_oe_n_out));
   phport_periph_model peer (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .request_in(xfer_request_out),
      .dir_in(ctrl_in.dir), .edge_sel_in(ctrl_in.edge_sel), .card_data_in(data_in),
      .ack_out(xfer_ack_in), .data_out(per_data), .oe_n_out(per_oe_n), .word_out(per_word),
      .sent_stb_out(sent_stb), .rx_stb_out(rx_stb));

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic check(input logic [17:0] seen, input logic [17:0] want);
      check_count++;
      if (seen !== want) begin
         error_cnt++;
         $display("wrong value at %0t: saw %0h expected %0h", $time, seen, want);
      end
   endtask

   task automatic take(input logic [`PHPORT_DATA_W-1:0] got);
      words++;
      if (exp_q.size() == 0) check(18'h1, 18'h0);
      else check(got, exp_q.pop_front());
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask

   task automatic give_verdict();
      if (error_cnt == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // FIFO side and result monitor
   // ----------------------------------------------------------------------
   always @(posedge clk_sys_in) begin
      sin = fifo_shift_in_pulse_out;
      sout = fifo_shift_out_out;
      if (rst_n_in) begin
         if (sent_stb) exp_q.push_back(per_word);
         if (sout) exp_q.push_back(fifo_rd_data_in);
         if (sin) take(fifo_wr_data_out);
         if (rx_stb) take(per_word);
         if (!data_oe_n_out && !per_oe_n) check(18'h1, 18'h0);
         if (!ctrl_in.dir && xfer_request_out && !req_q) begin
            check(18'(rdy_q), 18'h1F);
            check(18'(low_cnt >= MINLOW), 18'h1);
         end
         if (req_q && !xfer_request_out && ctrl_in.periph_enable)
            check(18'(xfer_ack_in ^ ctrl_in.edge_sel), 18'h0);
         low_cnt = xfer_request_out ? 0 : low_cnt + 1;
      end
      req_q = xfer_request_out;
      rdy_q = fifo_input_ready_in;
      #1;
      if (sin) rdy_wait = $urandom_range(1, 9);
      fifo_input_ready_in = (rdy_wait > 0) ? 5'(~$urandom_range(1, 31)) : '1;
      if (rdy_wait > 0) rdy_wait--;
      if (sout) fifo_rd_data_in = 18'($urandom);
   end

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      void'($urandom(32'h4FEBB61C));
      step(20);
      check(18'({direction_out_pair_n_out, data_oe_n_out, attention_input_sense_n_out}), 18'h7);
      rst_n_in = 1'h1;
      for (i = 0; i < 8; i++) begin
         ctrl_in = phport_ctrl_t'(7'($urandom) & 7'h79);
         status_bits_in = 3'($urandom);
         step(4);
         check(18'(ctrl_bits_out), 18'(ctrl_in.ctrl_bits));
         check(18'({direction_out_pair_p_out, direction_out_pair_n_out, data_oe_n_out}),
            18'({ctrl_in.dir, !ctrl_in.dir, !ctrl_in.dir}));
         check(18'({status_bits_out, ack_status_out}), 18'({status_bits_in, 1'h0}));
      end
      ctrl_in = '0;
      ctrl_in.attention_input_req_enable = 1'h1;
      for (i = 0; i < 2; i++) begin
         attention_input_in = 1'h1;
         attention_input_poll_in = 1'h1;
         step(5);
         attention_input_in = '0;
         check(18'({attention_input_sense_n_out, attention_input_req_n_out, attention_input_poll_resp_out}), 18'h1);
         ctrl_in.attention_input_req_enable = i[0] ? 1'h0 : 1'h1;
         step(2);
         check(18'({attention_input_req_n_out, attention_input_poll_resp_out}), 18'({i[0], !i[0]}));
         if (i == 1) device_clear_in = 1'h1;
         else status_read_in = 1'h1;
         step(1);
         device_clear_in = '0;
         status_read_in = '0;
         step(2);
         check(18'(attention_input_sense_n_out), 18'h1);
      end
      attention_input_poll_in = '0;
      srq_poll_in = 1'h1;
      for (i = 0; i < 4; i++) begin
         ctrl_in.dir = i[1];
         fifo_not_empty_in = i[0];
         step(2);
         check(18'(srq_poll_resp_out), 18'(i[1] | i[0]));
      end
      srq_poll_in = '0;
      for (i = 0; i < 4; i++) begin
         ctrl_in.dir = i[0];
         ctrl_in.edge_sel = i[1];
         step(5);
         ctrl_in.periph_enable = 1'h1;
         fifo_rd_valid_in = i[0];
         words = 0;
         for (int k = 0; k < 3000 && words < 6; k++) step(1);
         if (words < 6) begin
            check(18'(words), 18'h6);
            give_verdict();
         end
         ctrl_in.periph_enable = '0;
         fifo_rd_valid_in = '0;
         step(60);
         exp_q.delete();
      end
      give_verdict();
   end
endmodule
